// file: cedp_page_regs.sv
// Control and status page of the equalizer and its two output drivers.
// Assumes register accesses arrive on clk from the serial-port logic, with page selection
// supplied from the shared page, and analog status arriving asynchronously.
`timescale 1ns/100ps
module cedp_page_regs
  import cedp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Page selection from the shared page
  input wire logic page_select_enable,
  input wire logic [1:0] page_select,
  // Register access
  input wire cedp_access_s acc,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Analog core status
  input wire cedp_analog_s analog_in,
  // Pins and driver controls
  output logic detect_indicator_pin_n,
  output logic eq_power_save,
  output logic first_output_drive_en,
  output logic second_output_drive_en,
  output logic first_output_silenced_flag,
  output logic second_output_silenced_flag
);

  // Reset release
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_in_n;

  // Registers
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] thr_q;
  logic [7:0] thr_d;
  logic [7:0] rsvd_q [4:11];
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic rd_valid_q;
  logic power_save_q;
  logic [1:0] mute_q;
  logic detect_n_q;

  // Decode wires
  cedp_analog_s ana_s;
  logic page_hit;
  logic wr_en;
  logic rd_en;
  logic wr_ctrl;
  logic wr_thr;
  logic wr_rsvd;
  logic soft_rst;
  logic [3:0] acc_idx;
  logic ps_now;
  logic [1:0] mute_now;
  logic detect_src;
  logic [7:0] stat_val;
  logic [7:0] obs_val;

  // Release reset through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_in_n = rst_sync_q;

  // Analog status enters the clock domain
  cedp_sync #(
    .W($bits(cedp_analog_s))
  ) u_sync (
    .clk(clk),
    .rst_n(rst_in_n),
    .d_async(analog_in),
    .q_sync(ana_s)
  );

  // Access is served only while this page is selected
  assign page_hit = acc.valid && page_select_enable && (page_select == PAGE_CODE);
  assign wr_en = page_hit && acc.write;
  assign rd_en = page_hit && !acc.write;
  assign acc_idx = acc.addr[3:0];

  // Write decode; status registers have no write path
  assign wr_ctrl = wr_en && (acc.addr == OFS_CTRL);
  assign wr_thr = wr_en && (acc.addr == OFS_THR);
  assign wr_rsvd = wr_en && (acc.addr >= OFS_RSVD_LO) && (acc.addr <= OFS_RSVD_HI);
  assign soft_rst = wr_ctrl && acc.wdata[BIT_SRST];

  // Next values; the reset bit never stores
  assign ctrl_d = wr_ctrl ? (acc.wdata & SRST_MASK) : ctrl_q;
  assign thr_d = wr_thr ? acc.wdata : thr_q;

  // Power-save and mute decision
  cedp_mute_ctrl u_mute (
    .override_en(ctrl_q[BIT_OVR]),
    .ps_field(ctrl_q[BIT_PS_HI:BIT_PS_LO]),
    .threshold(thr_q[5:0]),
    .carrier(ana_s.carrier),
    .level(ana_s.level),
    .out_off(ana_s.out_off),
    .power_save(ps_now),
    .mute(mute_now)
  );

  // Detect pin source selection
  assign detect_src = ctrl_q[BIT_DSEL] ? ana_s.carrier : ana_s.adapt_done;

  // Status and observation read values
  assign stat_val = {STAT_RSVD, ana_s.adapt_done};
  assign obs_val = {1'b0, ana_s.carrier, ana_s.rate, power_save_q, mute_q};

  // Read mux; unmapped offsets read zero
  assign rd_data_d = (acc.addr == OFS_CTRL) ? ctrl_q :
                     (acc.addr == OFS_STAT) ? stat_val :
                     (acc.addr == OFS_OBS) ? obs_val :
                     (acc.addr == OFS_THR) ? thr_q :
                     ((acc.addr >= OFS_RSVD_LO) && (acc.addr <= OFS_RSVD_HI)) ? rsvd_q[acc_idx] : 8'h00;

  // Control and threshold registers
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      ctrl_q <= RST_CTRL;
      thr_q <= RST_THR;
    end else if (soft_rst) begin
      ctrl_q <= RST_CTRL;
      thr_q <= RST_THR;
    end else begin
      ctrl_q <= ctrl_d;
      thr_q <= thr_d;
    end
  end

  // Reserved registers keep what is written
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      for (int i = 4; i <= 11; i++) begin
        rsvd_q[i] <= cedp_rsvd_default(4'(i));
      end
    end else begin
      for (int i = 4; i <= 11; i++) begin
        if (soft_rst) begin
          rsvd_q[i] <= cedp_rsvd_default(4'(i));
        end else if (wr_rsvd && (acc_idx == 4'(i))) begin
          rsvd_q[i] <= acc.wdata;
        end
      end
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  // Registered driver, power and pin state
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      power_save_q <= 1'b1;
      mute_q <= 2'h3;
      detect_n_q <= 1'b1;
    end else begin
      power_save_q <= ps_now;
      mute_q <= mute_now;
      detect_n_q <= !detect_src;
    end
  end

  // Outputs; a muted driver stays at common mode
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign detect_indicator_pin_n = detect_n_q;
  assign eq_power_save = power_save_q;
  assign first_output_drive_en = !mute_q[0];
  assign second_output_drive_en = !mute_q[1];
  assign first_output_silenced_flag = mute_q[0];
  assign second_output_silenced_flag = mute_q[1];

  // Checks on the pin source selection
  property p_detect_adapt;
    @(posedge clk) disable iff (!rst_in_n)
    !ctrl_q[BIT_DSEL] |=> (detect_indicator_pin_n == !$past(ana_s.adapt_done));
  endproperty
  a_detect_adapt: assert property (p_detect_adapt) else $error("detect pin not following adaptation");

  property p_detect_carrier;
    @(posedge clk) disable iff (!rst_in_n)
    ctrl_q[BIT_DSEL] |=> (detect_indicator_pin_n == !$past(ana_s.carrier));
  endproperty
  a_detect_carrier: assert property (p_detect_carrier) else $error("detect pin not following carrier");

  // Checks on power save
  property p_ps_auto;
    @(posedge clk) disable iff (!rst_in_n)
    !ctrl_q[BIT_OVR] |=> (eq_power_save == !$past(ana_s.carrier));
  endproperty
  a_ps_auto: assert property (p_ps_auto) else $error("automatic power save wrong");

  property p_ps_force;
    @(posedge clk) disable iff (!rst_in_n)
    (ctrl_q[BIT_OVR] && (ctrl_q[BIT_PS_HI:BIT_PS_LO] == PS_FORCE)) |=> eq_power_save;
  endproperty
  a_ps_force: assert property (p_ps_force) else $error("forced power save not active");

  property p_ps_never;
    @(posedge clk) disable iff (!rst_in_n)
    (ctrl_q[BIT_OVR] && (ctrl_q[BIT_PS_HI:BIT_PS_LO] == PS_NEVER)) |=> !eq_power_save;
  endproperty
  a_ps_never: assert property (p_ps_never) else $error("power save active while disabled");

  // Soft reset: write the bit, then defaults and a clear bit
  sequence s_soft_write;
    wr_ctrl && acc.wdata[BIT_SRST];
  endsequence

  sequence s_defaults;
    (ctrl_q == RST_CTRL) && (thr_q == RST_THR) && (rsvd_q[11] == cedp_rsvd_default(4'hB));
  endsequence

  property p_soft_reset;
    @(posedge clk) disable iff (!rst_in_n)
    s_soft_write |=> s_defaults;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults");

  property p_srst_clear;
    @(posedge clk) disable iff (!rst_in_n)
    !ctrl_q[BIT_SRST];
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("reset bit did not self clear");

  // Read-back of status and observation
  property p_read_status;
    @(posedge clk) disable iff (!rst_in_n)
    (rd_en && (acc.addr == OFS_STAT)) |=> (rd_valid && (rd_data == {STAT_RSVD, $past(ana_s.adapt_done)}));
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  property p_read_obs;
    @(posedge clk) disable iff (!rst_in_n)
    (rd_en && (acc.addr == OFS_OBS)) |=>
      (rd_data[6:0] == {$past(ana_s.carrier), $past(ana_s.rate), $past(power_save_q), $past(mute_q)});
  endproperty
  a_read_obs: assert property (p_read_obs) else $error("observation read wrong");

  // Mute follows threshold; muted driver disabled
  property p_mute_thr;
    @(posedge clk) disable iff (!rst_in_n)
    (ana_s.level < thr_q[5:0]) |=> (!first_output_drive_en && !second_output_drive_en && (mute_q == 2'h3));
  endproperty
  a_mute_thr: assert property (p_mute_thr) else $error("outputs not muted below threshold");

  // Status writes leave the control and threshold registers unchanged
  property p_ro_write;
    @(posedge clk) disable iff (!rst_in_n)
    (wr_en && ((acc.addr == OFS_STAT) || (acc.addr == OFS_OBS))) |=> ($stable(ctrl_q) && $stable(thr_q));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("status write changed a register");

endmodule

// file: cedp_pkg.sv
// Package for the equalizer/driver control page: offsets, fields, codes, defaults, types.
// Assumes a single 10 MHz clock shared with the serial-port register access logic.
package cedp_pkg;

  // Register offsets on this page
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h01;
  localparam logic [7:0] OFS_OBS = 8'h02;
  localparam logic [7:0] OFS_THR = 8'h03;
  localparam logic [7:0] OFS_RSVD_LO = 8'h04;
  localparam logic [7:0] OFS_RSVD_HI = 8'h0B;

  // Page selection, as written to the shared page
  localparam logic [1:0] PAGE_CODE = 2'h1;

  // Field positions in the control register
  localparam int BIT_DSEL = 7;
  localparam int BIT_OVR = 5;
  localparam int BIT_PS_HI = 4;
  localparam int BIT_PS_LO = 3;
  localparam int BIT_SRST = 2;

  // Power-save field codes
  localparam logic [1:0] PS_AUTO = 2'h0;
  localparam logic [1:0] PS_NEVER = 2'h1;
  localparam logic [1:0] PS_RSVD = 2'h2;
  localparam logic [1:0] PS_FORCE = 2'h3;

  // Detected rate codes
  localparam logic [2:0] RATE_SD = 3'h1;
  localparam logic [2:0] RATE_HD3G = 3'h2;

  // Values after reset, the write mask that drops the reset bit, and the fixed status bits
  localparam logic [7:0] RST_CTRL = 8'h08;
  localparam logic [7:0] RST_THR = 8'h3F;
  localparam logic [7:0] SRST_MASK = 8'hFB;
  localparam logic [6:0] STAT_RSVD = 7'h40;

  // Status from the analog core, asynchronous to clk
  typedef struct packed {
    logic adapt_done;
    logic carrier;
    logic [2:0] rate;
    logic [5:0] level;
    logic [1:0] out_off;
  } cedp_analog_s;

  // One register access from the serial port
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cedp_access_s;

  // Default of a reserved read-write register, by offset
  function automatic logic [7:0] cedp_rsvd_default(input logic [3:0] idx);
    case (idx)
      4'h6: cedp_rsvd_default = 8'hA0;
      4'h7: cedp_rsvd_default = 8'h24;
      4'h8: cedp_rsvd_default = 8'h27;
      4'h9: cedp_rsvd_default = 8'h01;
      4'hA: cedp_rsvd_default = 8'h05;
      4'hB: cedp_rsvd_default = 8'h37;
      default: cedp_rsvd_default = 8'h00;
    endcase
  endfunction

endpackage

// file: cedp_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/100ps
module cedp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages, first read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_async;
      sync_q <= meta_q;
    end
  end

  assign q_sync = sync_q;

endmodule

// file: cedp_mute_ctrl.sv
// Power-save and mute decision for the equalizer and both output drivers.
// Assumes synchronised analog status; result is combinational, registered by the caller.
`timescale 1ns/100ps
module cedp_mute_ctrl
  import cedp_pkg::*;
(
  // Control fields
  input wire logic override_en,
  input wire logic [1:0] ps_field,
  input wire logic [5:0] threshold,
  // Analog status
  input wire logic carrier,
  input wire logic [5:0] level,
  input wire logic [1:0] out_off,
  // Decisions
  output logic power_save,
  output logic [1:0] mute
);

  logic auto_ps;
  logic manual_ps;
  logic below_thr;

  // Automatic rule: save power when no input is seen
  assign auto_ps = !carrier;

  // Manual field, reserved code treated like the automatic one
  assign manual_ps = (ps_field == PS_FORCE) ? 1'b1 :
                     (ps_field == PS_NEVER) ? 1'b0 : auto_ps;

  assign power_save = override_en ? manual_ps : auto_ps;

  // Mute when level drops under the threshold, in power save, or powered down
  assign below_thr = (level < threshold);
  assign mute[0] = below_thr || power_save || out_off[0];
  assign mute[1] = below_thr || power_save || out_off[1];

endmodule

// file: cedp_host_model.sv
// Host side of the register page: page selection and one-cycle register accesses.
// Assumes the page answers a read one cycle after the access edge; drives on falling edges.
`timescale 1ns/100ps
module cedp_host_model
  import cedp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Page selection and access
  output logic page_select_enable,
  output logic [1:0] page_select,
  output cedp_access_s acc,
  // Read answer
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  // Idle until the bench selects a page
  initial begin
    page_select_enable = 1'b0;
    page_select = 2'h0;
    acc = '0;
  end

  // Shared page selection, held as a level
  task automatic sel(input logic en, input logic [1:0] code);
    @(negedge clk);
    page_select_enable = en;
    page_select = code;
  endtask

  // One access for one edge, answer taken in the following cycle
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] got, output logic seen);
    @(negedge clk);
    acc = '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(negedge clk);
    got = rd_data;
    seen = rd_valid;
    acc.valid = 1'b0;
  endtask
endmodule

// file: cable_eq_driver_page_regs_test.sv
// Self-checking bench for the equalizer/driver page: registers, power save, mute, detect pin.
// Assumes analog status is a set of slow levels that reach the outputs within four cycles.
`timescale 1ns/100ps
module cable_eq_driver_page_regs_test;
  import cedp_pkg::*;
  logic clk, rst_n, seen, e;
  logic [7:0] got;
  cedp_analog_s an;
  logic page_select_enable, rd_valid, pin_n, ps, en0, en1, f0, f1;
  logic [1:0] page_select;
  logic [7:0] rd_data;
  cedp_access_s acc;
  int miscompares, compares, cycles, i, ovr, fld, car;
  localparam logic [7:0] DEF [12] = '{8'h08, 8'h80, 8'h07, 8'h3F, 8'h00, 8'h00,
                                      8'hA0, 8'h24, 8'h27, 8'h01, 8'h05, 8'h37};

  // Host and page
  cedp_host_model i_host (.clk(clk), .page_select_enable(page_select_enable),
    .page_select(page_select), .acc(acc), .rd_data(rd_data), .rd_valid(rd_valid));
  cedp_page_regs i_dut (.clk(clk), .rst_n(rst_n), .page_select_enable(page_select_enable),
    .page_select(page_select), .acc(acc), .rd_data(rd_data), .rd_valid(rd_valid),
    .analog_in(an), .detect_indicator_pin_n(pin_n), .eq_power_save(ps),
    .first_output_drive_en(en0), .second_output_drive_en(en1),
    .first_output_silenced_flag(f0), .second_output_silenced_flag(f1));

  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] x, input logic [7:0] g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chk1(input string nm, input logic x, input logic g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", nm, x, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    i_host.access(1'b0, a, 8'h00, got, seen);
    chk1("rd_valid", 1'b1, seen);
    chk8($sformatf("register %h", a), x, got);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.access(1'b1, a, d, got, seen);
  endtask

  // Analog change needs two sync edges and one output edge
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // Power save expected from override, field and carrier
  function automatic logic exp_ps(input logic o, input logic [1:0] f, input logic c);
    if (!o) return !c;
    case (f)
      2'h1: return 1'b0;
      2'h3: return 1'b1;
      default: return !c;
    endcase
  endfunction

  // Main sequence
  initial begin
    an = '0;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    i_host.sel(1'b1, PAGE_CODE);
    for (i = 0; i < 12; i++) rd_chk(i[7:0], DEF[i]);
    rd_chk(8'h0C, 8'h00);
    chk1("detect pin", 1'b1, pin_n);
    // Read-only places ignore writes, reserved bits store
    wr(8'h01, 8'hFF);
    wr(8'h02, 8'hFF);
    rd_chk(8'h01, 8'h80);
    rd_chk(8'h02, 8'h07);
    wr(8'h00, 8'hFB);
    rd_chk(8'h00, 8'hFB);
    wr(8'h04, 8'hAA);
    rd_chk(8'h04, 8'hAA);
    // Soft reset restores defaults and clears itself
    wr(8'h03, 8'h15);
    wr(8'h00, 8'h04);
    rd_chk(8'h00, 8'h08);
    rd_chk(8'h03, 8'h3F);
    rd_chk(8'h04, 8'h00);
    wr(8'h03, 8'h3F);
    // Accesses without this page selected are dropped
    for (i = 0; i < 2; i++) begin
      // Enable low with a bad code, then enable high with another bad code
      i_host.sel(i[0], 2'h2 + i[1:0]);
      wr(8'h03, 8'h11);
      i_host.access(1'b0, 8'h03, 8'h00, got, seen);
      chk1("rd_valid", 1'b0, seen);
    end
    i_host.sel(1'b1, PAGE_CODE);
    rd_chk(8'h03, 8'h3F);
    // Detect pin source selection
    an.adapt_done = 1'b1;
    settle();
    chk1("detect pin", 1'b0, pin_n);
    rd_chk(8'h01, 8'h81);
    wr(8'h00, 8'h80);
    settle();
    chk1("detect pin", 1'b1, pin_n);
    an.carrier = 1'b1;
    settle();
    chk1("detect pin", 1'b0, pin_n);
    // Every override and field code, with and without carrier
    an.level = 6'h3F;
    for (ovr = 0; ovr < 2; ovr++)
      for (fld = 0; fld < 4; fld++)
        for (car = 0; car < 2; car++) begin
          an.carrier = car[0];
          wr(8'h00, {2'h0, ovr[0], fld[1:0], 3'h0});
          settle();
          e = exp_ps(ovr[0], fld[1:0], car[0]);
          chk1("power save", e, ps);
          chk1("first silenced", e, f0);
          chk1("first drive", !e, en0);
          rd_chk(8'h02, {1'b0, car[0], 3'h0, e, e, e});
        end
    // Threshold boundary, rate codes and one output powered down
    wr(8'h00, 8'h28);
    wr(8'h03, 8'h20);
    an.level = 6'h1F;
    an.rate = RATE_SD;
    settle();
    rd_chk(8'h02, {2'h1, RATE_SD, 3'h3});
    an.level = 6'h20;
    an.rate = RATE_HD3G;
    an.out_off = 2'h2;
    settle();
    rd_chk(8'h02, {2'h1, RATE_HD3G, 3'h2});
    chk1("second drive", 1'b0, en1);
    chk1("second silenced", 1'b1, f1);
    chk1("first drive", 1'b1, en0);
    print_verdict();
  end
endmodule
